// ### rtl/angle_interlace.sv
// angular address interlace permutation
`timescale 1ns/10ps
module angle_interlace
   import drum_locator_pkg::*;
(
   input wire logic [ANGLE_W-1:0] angle,
   input wire logic [SEL_W-1:0] sel,
   output logic [ANGLE_W-1:0] mapped
);
   logic [2*ANGLE_W-1:0] doubled;
   logic [3:0] shift;

   ////////////////////////////////////////////////////////////
   // rotate left so every position is reached exactly once
   always_comb
   begin
      doubled = {angle, angle};
      if (sel == SEL_ADJACENT || sel > SEL_MAX)
         shift = 4'h0;
      else
         shift = 4'(sel) + 4'(SHIFT_BASE);
      mapped = doubled[2*ANGLE_W-1-shift -: ANGLE_W];
   end
endmodule : angle_interlace

// ### rtl/drum_locator.sv
// drum head-group selection, read settling and angular locating
// Summary of operation
// - address is 15 bits: group in bits 13:12, angle in the low twelve
// - each reference compares requested group with stored selection; equal keeps it
// - a different group loads the two selection flip-flops
// - selection decodes to exactly one of four head-bank enables
// - the bank enable holds until another group is selected
// - a read needing a bank switch waits about 32 us
// - switched read raises deferred start; no probing while the delay runs
// - a read on the same bank gets an immediate start, no delay
// - writes never wait for settling
// - 12-stage index counter advances one per phase-zero pulse
// - a probe finding count equal to interlaced angle sends a match pulse
// - interlace rotates the angle left two to six bits for 4-way up to 64-way
// - one interlace setting at a time; one setting maps addresses unchanged
// - interlace leaves the group bits alone
// - revolution index pulse when a tick meets the index window
// - after index, next 4096 positions are numbered 0 to 4095
// - after 4096 positions locating idles until the next index
// - locating tracks the drum whether or not a reference runs
// - first phase-zero after index presets the counter to all ones
`timescale 1ns/10ps
module drum_locator
   import drum_locator_pkg::*;
#(
   parameter int SETTLE_LEN = SETTLE_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [PINS-1:0] drum_pins,
   input wire drum_req_t req,
   input wire reg_req_t bus,
   output logic [31:0] rdata,
   output logic [BANKS-1:0] bank_enable,
   output logic read_start,
   output logic deferred_read_start,
   output logic match_pulse,
   output logic rev_index_pulse,
   output logic busy
);
   typedef enum logic [1:0] {LOC_DEAD, LOC_PRESET, LOC_ROLL, LOC_COUNT} loc_state_t;
   typedef enum logic [1:0] {ACC_IDLE, ACC_SETTLE, ACC_READ, ACC_WRITE} acc_state_t;

   logic [PINS-1:0] pin_meta;
   logic [PINS-1:0] pin_sync;
   logic [PINS-1:0] pin_last;
   logic [PINS-1:0] pin_rise;
   logic tick;
   logic phase0;
   logic group_sel_bit_one;
   logic group_sel_bit_two;
   logic [GROUP_W-1:0] group_sel;
   logic [GROUP_W-1:0] req_group;
   logic accept;
   logic switch_bank;
   logic [SEL_W-1:0] interlace_sel;
   logic [ANGLE_W-1:0] mapped_angle;
   logic [ANGLE_W-1:0] angular_index_counter;
   logic [31:0] settle_cnt;
   logic probe;
   logic hit;
   loc_state_t loc;
   acc_state_t acc;

   ////////////////////////////////////////////////////////////
   // pin synchronisers, one per drum pin
   genvar g;
   generate
      for (g = 0; g < PINS; g++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               pin_meta[g] <= 1'b0;
               pin_sync[g] <= 1'b0;
               pin_last[g] <= 1'b0;
            end
            else
            begin
               pin_meta[g] <= drum_pins[g];
               pin_sync[g] <= pin_meta[g];
               pin_last[g] <= pin_sync[g];
            end
         end
         assign pin_rise[g] = pin_sync[g] & ~pin_last[g];
      end
   endgenerate

   assign tick = pin_rise[PIN_TICK];
   assign phase0 = pin_rise[PIN_PHASE0];

   ////////////////////////////////////////////////////////////
   // group detection
   assign group_sel = {group_sel_bit_two, group_sel_bit_one};
   assign req_group = req.addr[GROUP_LSB +: GROUP_W];
   // references are taken only while no other one is running
   assign accept = req.ref_req && acc == ACC_IDLE;
   assign switch_bank = req_group != group_sel;

   // selection flip-flops only move on a differing group
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         group_sel_bit_one <= 1'b0;
         group_sel_bit_two <= 1'b0;
      end
      else if (accept && switch_bank)
      begin
         group_sel_bit_one <= req_group[0];
         group_sel_bit_two <= req_group[1];
      end
   end

   // bank enables kept in step with the selection, one-hot
   always_ff @(posedge clk)
   begin
      if (rst)
         bank_enable <= 4'h1;
      else if (accept && switch_bank)
         bank_enable <= 4'(1) << req_group;
   end

   ////////////////////////////////////////////////////////////
   // interlace of the angle; group bits never enter the mapper
   angle_interlace u_interlace (
      .angle(req.addr[ANGLE_W-1:0]),
      .sel(interlace_sel),
      .mapped(mapped_angle)
   );

   ////////////////////////////////////////////////////////////
   // access sequencing: settle, read, write
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc <= ACC_IDLE;
         settle_cnt <= 32'h0;
      end
      else
      begin
         case (acc)
            ACC_IDLE:
               if (accept && req.wr_req)
                  acc <= ACC_WRITE;
               else if (accept && req.rd_req && switch_bank)
               begin
                  acc <= ACC_SETTLE;
                  settle_cnt <= 32'(SETTLE_LEN - 1);
               end
               else if (accept && req.rd_req)
                  acc <= ACC_READ;
            ACC_SETTLE:
               if (settle_cnt == 32'h0)
                  acc <= ACC_READ;
               else
                  settle_cnt <= settle_cnt - 32'h1;
            ACC_READ, ACC_WRITE:
               if (hit)
                  acc <= ACC_IDLE;
            default:
               acc <= ACC_IDLE;
         endcase
      end
   end

   // start pulses to the access control, one cycle each
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         read_start <= 1'b0;
         deferred_read_start <= 1'b0;
      end
      else
      begin
         read_start <= accept && req.rd_req && !req.wr_req && !switch_bank;
         deferred_read_start <= accept && req.rd_req && !req.wr_req && switch_bank;
      end
   end

   ////////////////////////////////////////////////////////////
   // probing: only inside the counted span and never while settling
   assign probe = phase0 && loc == LOC_COUNT && (acc == ACC_READ || acc == ACC_WRITE);
   // address held by the master for the whole reference
   assign hit = probe && angular_index_counter == mapped_angle;

   always_ff @(posedge clk)
   begin
      if (rst)
         match_pulse <= 1'b0;
      else
         match_pulse <= hit;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         busy <= 1'b0;
      else
         busy <= acc != ACC_IDLE || accept;
   end

   ////////////////////////////////////////////////////////////
   // revolution index: tick seen while the window is open
   always_ff @(posedge clk)
   begin
      if (rst)
         rev_index_pulse <= 1'b0;
      else
         rev_index_pulse <= tick && pin_sync[PIN_WINDOW];
   end

   // locating runs free of references; counter keeps moving in dead space
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         loc <= LOC_DEAD;
         angular_index_counter <= 12'h000;
      end
      else if (tick && pin_sync[PIN_WINDOW])
         loc <= LOC_PRESET;
      else if (phase0)
      begin
         case (loc)
            LOC_PRESET:
            begin
               angular_index_counter <= ANGLE_LAST;
               loc <= LOC_ROLL;
            end
            LOC_ROLL:
            begin
               angular_index_counter <= angular_index_counter + 12'h001;
               loc <= LOC_COUNT;
            end
            LOC_COUNT:
            begin
               angular_index_counter <= angular_index_counter + 12'h001;
               if (angular_index_counter == ANGLE_LAST)
                  loc <= LOC_DEAD;
            end
            LOC_DEAD:
               angular_index_counter <= angular_index_counter + 12'h001;
            default:
               loc <= LOC_DEAD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // register port; invalid interlace codes are dropped so one setting stays
   always_ff @(posedge clk)
   begin
      if (rst)
         interlace_sel <= CTRL_RESET;
      else if (bus.wr && bus.addr == REG_CTRL && bus.wdata[SEL_W-1:0] <= SEL_MAX)
         interlace_sel <= bus.wdata[SEL_W-1:0];
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         rdata <= 32'h0;
      else if (!bus.rd)
         rdata <= 32'h0;
      else
      begin
         case (bus.addr)
            REG_CTRL: rdata <= 32'(interlace_sel);
            REG_STATUS: rdata <= 32'(group_sel) | (32'(loc != LOC_COUNT) << ST_LOCKOUT)
               | (32'(acc == ACC_SETTLE) << ST_SETTLING) | (32'(acc != ACC_IDLE) << ST_BUSY);
            REG_INDEX: rdata <= 32'(angular_index_counter);
            default: rdata <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // checks beside the logic
   a_group_hold: assert property (@(posedge clk) disable iff (rst)
      accept && !switch_bank |=> $stable(group_sel))
      else $error("group selection moved on an equal group");

   a_group_load: assert property (@(posedge clk) disable iff (rst)
      accept |=> group_sel == $past(req_group))
      else $error("group selection not loaded");

   a_bank_decode: assert property (@(posedge clk) disable iff (rst)
      bank_enable == 4'(1) << group_sel)
      else $error("bank enable not the decoded group");

   a_bank_steady: assert property (@(posedge clk) disable iff (rst)
      !accept |=> $stable(bank_enable))
      else $error("bank enable changed without a reference");

   a_settle_end: assert property (@(posedge clk) disable iff (rst)
      acc == ACC_SETTLE && settle_cnt == 32'h0 |=> acc == ACC_READ)
      else $error("settle did not end into read");

   a_deferred_read: assert property (@(posedge clk) disable iff (rst)
      accept && req.rd_req && !req.wr_req && switch_bank |=> deferred_read_start && !read_start
      ##1 !match_pulse)
      else $error("switched read not deferred");

   a_settle_quiet: assert property (@(posedge clk) disable iff (rst)
      acc == ACC_SETTLE && settle_cnt != 32'h0 |=> acc == ACC_SETTLE && !match_pulse)
      else $error("probe while settling");

   a_direct_read: assert property (@(posedge clk) disable iff (rst)
      accept && req.rd_req && !req.wr_req && !switch_bank |=> read_start && acc == ACC_READ)
      else $error("same bank read not immediate");

   a_write_direct: assert property (@(posedge clk) disable iff (rst)
      accept && req.wr_req |=> acc == ACC_WRITE)
      else $error("write delayed");

   a_index_step: assert property (@(posedge clk) disable iff (rst)
      phase0 && loc == LOC_COUNT && !tick
      |=> angular_index_counter == $past(angular_index_counter) + 12'h001)
      else $error("index counter did not advance");

   a_match_out: assert property (@(posedge clk) disable iff (rst)
      probe && angular_index_counter == mapped_angle |=> match_pulse ##1 !match_pulse)
      else $error("match pulse missing");

   a_index_pulse: assert property (@(posedge clk) disable iff (rst)
      tick && pin_sync[PIN_WINDOW] |=> rev_index_pulse && loc == LOC_PRESET)
      else $error("index pulse missing");

   a_preset_ones: assert property (@(posedge clk) disable iff (rst)
      phase0 && loc == LOC_PRESET && !tick |=> angular_index_counter == 12'hfff && loc == LOC_ROLL)
      else $error("preset not all ones");

   a_span_end: assert property (@(posedge clk) disable iff (rst)
      phase0 && !tick && loc == LOC_COUNT && angular_index_counter == 12'hfff |=> loc == LOC_DEAD)
      else $error("locating did not stop after 4096");
endmodule : drum_locator

// ### rtl/drum_locator_pkg.sv
// shared constants and carrier types for the drum group and angle locator
package drum_locator_pkg;
   // address layout: bits 13:12 pick group 0..3, bits 11:0 angle
   localparam int ADDR_W = 15;
   localparam int ANGLE_W = 12;
   localparam int GROUP_LSB = 12;
   localparam int GROUP_W = 2;
   localparam int BANKS = 4;
   localparam logic [ANGLE_W-1:0] ANGLE_LAST = 12'hfff;
   // interlace select codes: 0 adjacent, 1..5 give 4..64-way
   localparam int SEL_W = 3;
   localparam logic [SEL_W-1:0] SEL_ADJACENT = 3'h0;
   localparam logic [SEL_W-1:0] SEL_MAX = 3'h5;
   localparam int SHIFT_BASE = 1;
   // settling time after a bank switch before a read may probe
   localparam int SETTLE_NS = 32000;
   localparam int CLK_MHZ = 250;
   localparam int SETTLE_CYCLES = SETTLE_NS * CLK_MHZ / 1000;
   // register bus
   localparam int RADDR_W = 8;
   localparam logic [RADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [RADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [RADDR_W-1:0] REG_INDEX = 8'h08;
   localparam logic [SEL_W-1:0] CTRL_RESET = 3'h0;
   // status field positions
   localparam int ST_GROUP = 0;
   localparam int ST_LOCKOUT = 2;
   localparam int ST_SETTLING = 3;
   localparam int ST_BUSY = 4;
   // pin order inside the synchroniser vector
   localparam int PIN_TICK = 0;
   localparam int PIN_WINDOW = 1;
   localparam int PIN_PHASE0 = 2;
   localparam int PINS = 3;

   typedef struct packed {
      logic ref_req;
      logic rd_req;
      logic wr_req;
      logic [ADDR_W-1:0] addr;
   } drum_req_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [RADDR_W-1:0] addr;
      logic [31:0] wdata;
   } reg_req_t;
endpackage : drum_locator_pkg

// ### verification/drum_locator_test.sv
// self-checking bench for the drum group and angle locator
`timescale 1ns/10ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module drum_locator_test
   import drum_locator_pkg::*;
;
   localparam int SETTLE = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [PINS-1:0] drum_pins;
   drum_req_t req = '0;
   reg_req_t bus = '0;
   logic [31:0] rdata;
   logic [BANKS-1:0] bank_enable;
   logic read_start, deferred_read_start, match_pulse, rev_index_pulse, busy;
   int fails = 0;
   int checked = 0;
   int cycles = 0;

   drum_locator #(.SETTLE_LEN(SETTLE)) drum_locator_i (.clk(clk), .rst(rst), .drum_pins(drum_pins), .req(req),
      .bus(bus), .rdata(rdata), .bank_enable(bank_enable), .read_start(read_start),
      .deferred_read_start(deferred_read_start), .match_pulse(match_pulse), .rev_index_pulse(rev_index_pulse),
      .busy(busy));
   drum_pin_model drum_pin_model_i (.clk(clk), .pins(drum_pins));

   ////////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock and a hang guard well past the longest expected run
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 100000)
      begin
         fails++;
         print_verdict();
      end
   end

   // rotation by the interlace code; code 0 is the adjacent mapping
   function automatic logic [11:0] rot(input logic [11:0] a, input int n, input bit left);
      if (n == 0)
         return a;
      return left ? ((a << n) | (a >> (12 - n))) : ((a >> n) | (a << (12 - n)));
   endfunction : rot

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      bus <= '0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= {1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      bus <= '0;
      #1;
      d = rdata;
   endtask : reg_rd

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset, wait for locating, then a run of references
   initial
   begin
      logic [31:0] d;
      logic [1:0] grp, cur;
      logic [11:0] target;
      logic [2:0] sel;
      logic wr, sw;
      int off, cyc;
      void'($urandom(32'h4bd96ec3));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHECK(bank_enable, 4'h1)
      `CHECK(busy, 1'b0)
      cur = 2'h0;
      cyc = 0;
      while (rev_index_pulse !== 1'b1 && cyc < 40000)
      begin
         @(posedge clk);
         #1;
         cyc++;
      end
      `CHECK(rev_index_pulse, 1'b1)
      // right after the index the counted span has not begun yet
      reg_rd(REG_STATUS, d);
      `CHECK(d[ST_LOCKOUT], 1'b1)
      reg_rd(8'h0c, d);
      `CHECK(d, 32'h0)
      for (int i = 0; i < 12; i++)
      begin
         sel = 3'(i % 6);
         reg_wr(REG_CTRL, {29'h0, sel});
         reg_wr(REG_CTRL, 32'h6);
         reg_rd(REG_CTRL, d);
         `CHECK(d[2:0], sel)
         grp = (i % 3 == 0) ? cur : 2'($urandom);
         wr = (i % 4 == 3);
         sw = (grp != cur);
         off = wr ? 2 : 8 + int'($urandom % 120);
         reg_rd(REG_INDEX, d);
         target = d[11:0] + 12'(off);
         @(posedge clk);
         req <= {1'b1, ~wr | 1'($urandom), wr, 1'($urandom), grp, rot(target, (sel == 0) ? 0 : sel + 1, 1'b0)};
         @(posedge clk);
         req.ref_req <= 1'b0;
         req.rd_req <= 1'b0;
         req.wr_req <= 1'b0;
         #1;
         `CHECK(read_start, ~wr & ~sw)
         `CHECK(deferred_read_start, ~wr & sw)
         `CHECK(bank_enable, 4'h1 << grp)
         `CHECK(busy, 1'b1)
         // only a switched read may sit in the settling wait; writes go straight on
         reg_rd(REG_STATUS, d);
         `CHECK({d[ST_BUSY], d[ST_SETTLING]}, {1'b1, ~wr & sw})
         cyc = 0;
         while (match_pulse !== 1'b1 && cyc < 20000)
         begin
            @(posedge clk);
            #1;
            cyc++;
         end
         `CHECK(match_pulse, 1'b1)
         `CHECK(~wr & sw & (cyc <= SETTLE), 1'b0)
         reg_rd(REG_INDEX, d);
         `CHECK(d[11:0], target + 12'h1)
         reg_rd(REG_STATUS, d);
         `CHECK({d[ST_BUSY], d[ST_LOCKOUT], d[1:0]}, {1'b0, 1'b0, grp})
         cur = grp;
      end
      print_verdict();
   end
endmodule : drum_locator_test

// ### verification/drum_pin_model.sv
// drum side model: position ticks, index window and phase-zero pulses
`timescale 1ns/10ps
module drum_pin_model
   import drum_locator_pkg::*;
#(
   parameter int REV = 4100
)
(
   input wire logic clk,
   output logic [PINS-1:0] pins = 3'h0
);
   logic [2:0] slot = 3'h0;
   logic [12:0] pos = 13'(REV - 2);

   ////////////////////////////////////////////////////////////////////////////////
   // the drum keeps turning through reset; starting near the mark keeps the first wait short
   always_ff @(posedge clk)
   begin
      slot <= slot + 3'h1;
      if (slot == 3'h7)
      begin
         pos <= (pos == 13'(REV - 1)) ? 13'h0 : pos + 13'h1;
      end
   end

   // eight clocks a position: tick then phase-zero, each two clocks wide
   always_ff @(posedge clk)
   begin
      pins[PIN_TICK] <= (slot < 3'h2);
      pins[PIN_PHASE0] <= (slot == 3'h4) || (slot == 3'h5);
      // window brackets only the tick of position zero
      pins[PIN_WINDOW] <= (pos == 13'(REV - 1) && slot >= 3'h4) || (pos == 13'h0 && slot < 3'h4);
   end
endmodule : drum_pin_model
